// File: hw/ohci_cmd_pkg.sv
// Constants and carrier types for the command/status and event status block.
// Assumes a single 50 MHz controller clock shared by every user of this package.
package ohci_cmd_pkg;

	localparam int ADDR_W = 8;
	localparam logic [7:0] CMD_STATUS_OFFSET = 8'h08;
	localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h0c;
	localparam logic [31:0] REG_RESET_VALUE = 32'h0000_0000;

	// Command/status field positions
	localparam int CMD_SOFT_RESET_BIT = 0;
	localparam int CMD_CTRL_FILLED_BIT = 1;
	localparam int CMD_BULK_FILLED_BIT = 2;
	localparam int CMD_OWN_REQ_BIT = 3;
	localparam int OVERRUN_COUNT_LSB = 16;
	localparam int OVERRUN_COUNT_W = 2;

	// Event status field positions
	localparam int EVT_OVERRUN_BIT = 0;
	localparam int EVT_DONE_HEAD_BIT = 1;
	localparam int EVT_FRAME_START_BIT = 2;
	localparam int EVT_RESUME_BIT = 3;
	localparam int EVT_FATAL_BIT = 4;
	localparam int EVT_FRAME_OVF_BIT = 5;
	localparam int EVT_ROOTHUB_BIT = 6;
	localparam int EVT_OWN_CHANGED_BIT = 30;
	localparam int MASTER_IRQ_BIT = 31;
	localparam logic [31:0] EVT_IMPL_MASK = 32'h4000_007f;

	// Software reset timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SOFT_RESET_LIMIT_NS = 10000;
	localparam int SOFT_RESET_LIMIT_CYCLES = SOFT_RESET_LIMIT_NS / CLK_PERIOD_NS;
	localparam int SOFT_RESET_CNT_W = 9;
	localparam logic [SOFT_RESET_CNT_W-1:0] SOFT_RESET_CYCLES = 9'h010;

	typedef enum logic [0:0] {
		RST_IDLE = 1'b0,
		RST_BUSY = 1'b1
	} reset_state_t;

	// Events from a list walker to the filled-bit tracker
	typedef struct packed {
		logic head_reached;
		logic td_found;
		logic pass_done;
	} list_evt_t;

	// One-cycle answers from the tracker to the list walker
	typedef struct packed {
		logic start;
		logic skip;
		logic stop;
	} list_result_t;

endpackage

// File: hw/list_fill_tracker.sv
// Filled-bit tracker for one transfer list (control or bulk).
// Assumes the list walker gives one-cycle pulses on the controller clock.
`timescale 1ns/100ps
module list_fill_tracker
	import ohci_cmd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sw_set,
	input wire logic clear,
	input wire list_evt_t evt,
	output logic filled,
	output list_result_t result
);

	typedef struct packed {
		logic filled;
		list_result_t result;
	} trk_state_t;

	trk_state_t state_reg;
	trk_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.result = '0;
		if (evt.head_reached) begin
			if (state_reg.filled) begin
				state_next.result.start = 1'b1;
				state_next.filled = 1'b0;
			end else begin
				state_next.result.skip = 1'b1;
			end
		end
		// Tested against the held value, so a descriptor found in the same cycle still counts next pass
		if (evt.pass_done && !state_reg.filled) begin
			state_next.result.stop = 1'b1;
		end
		if (evt.td_found) begin
			state_next.filled = 1'b1;
		end
		if (clear) begin
			state_next.filled = 1'b0;
		end
		// A command write wins over any clear in the same cycle
		if (sw_set) begin
			state_next.filled = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign filled = state_reg.filled;
	assign result = state_reg.result;

endmodule

// File: hw/event_edge_detect.sv
// Edge detection for frame number MSB toggles and remote resume onset.
// Assumes all three level inputs are synchronous to the controller clock.
`timescale 1ns/100ps
module event_edge_detect
	import ohci_cmd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_msb,
	input wire logic resume_signal,
	input wire logic sw_resume,
	output logic frame_overflow,
	output logic resume_onset
);

	typedef struct packed {
		logic primed;
		logic prev_msb;
		logic prev_resume;
		logic frame_overflow;
		logic resume_onset;
	} edge_state_t;

	edge_state_t state_reg;
	edge_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.primed = 1'b1;
		state_next.prev_msb = frame_msb;
		state_next.prev_resume = resume_signal;
		// First cycle after reset only samples, so a high MSB at reset is not a toggle
		state_next.frame_overflow = state_reg.primed && (frame_msb != state_reg.prev_msb);
		state_next.resume_onset = state_reg.primed && resume_signal && !state_reg.prev_resume && !sw_resume;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign frame_overflow = state_reg.frame_overflow;
	assign resume_onset = state_reg.resume_onset;

endmodule

// File: hw/ohci_command_and_event_status.sv
// Command/status and event status registers of the open host controller core.
// Assumes the register port, list walker, frame counter and root hub share REF_CLK.
`timescale 1ns/100ps
module ohci_command_and_event_status
	import ohci_cmd_pkg::*;
#(
	parameter bit SMI_PRESENT = 1'b1
)
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic REG_CS,
	input wire logic REG_WE,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_ACK,
	input wire logic [31:0] EVENT_ENABLE,
	input wire logic SCHED_OVERRUN,
	input wire logic DONE_HEAD_COPIED,
	input wire logic FRAME_START,
	input wire logic FRAME_MSB,
	input wire logic RESUME_SIGNAL,
	input wire logic SW_RESUME,
	input wire logic FATAL_ERROR,
	input wire logic ROOTHUB_CHANGE,
	input wire logic OWNERSHIP_DONE,
	input wire list_evt_t CTRL_LIST_EVT,
	input wire list_evt_t BULK_LIST_EVT,
	output list_result_t CTRL_LIST_RESULT,
	output list_result_t BULK_LIST_RESULT,
	output logic DONE_HEAD_UPDATE_OK,
	output logic SOFT_RESET_BUSY,
	output logic FORCE_USB_SUSPEND,
	output logic BUS_ACCESS_INHIBIT,
	output logic PROCESSING_HALT,
	output logic HOST_IRQ,
	output logic SYSTEM_MGMT_IRQ_N
);

	typedef struct packed {
		reset_state_t rst_state;
		logic [SOFT_RESET_CNT_W-1:0] rst_cnt;
		logic soft_reset;
		logic own_req;
		logic [OVERRUN_COUNT_W-1:0] overrun_cnt;
		logic [31:0] evt;
		logic halted;
		logic [31:0] rdata;
		logic ack;
		logic irq;
		logic smi_n;
	} ctl_state_t;

	localparam ctl_state_t CTL_RESET = '{
		rst_state: RST_IDLE,
		rst_cnt: '0,
		soft_reset: 1'b0,
		own_req: 1'b0,
		overrun_cnt: '0,
		evt: REG_RESET_VALUE,
		halted: 1'b0,
		rdata: REG_RESET_VALUE,
		ack: 1'b0,
		irq: 1'b0,
		smi_n: 1'b1
	};

	ctl_state_t state_reg;
	ctl_state_t state_next;

	logic cmd_wr;
	logic evt_wr;
	logic reg_rd;
	logic ctrl_filled;
	logic bulk_filled;
	logic frame_overflow;
	logic resume_onset;
	logic busy;
	logic list_gate;
	list_evt_t list_evt_gated [2];
	logic list_filled [2];
	list_result_t list_result [2];
	logic [31:0] evt_set;
	logic [31:0] cmd_read;
	logic [31:0] evt_impl;

	assign cmd_wr = REG_CS && REG_WE && (REG_ADDR == CMD_STATUS_OFFSET);
	assign evt_wr = REG_CS && REG_WE && (REG_ADDR == EVENT_STATUS_OFFSET);
	assign reg_rd = REG_CS && !REG_WE;
	assign busy = (state_reg.rst_state == RST_BUSY);

	// List walking stops during a soft reset and after a fatal error
	assign list_gate = !busy && !state_reg.halted;
	assign list_evt_gated[0] = list_gate ? CTRL_LIST_EVT : '0;
	assign list_evt_gated[1] = list_gate ? BULK_LIST_EVT : '0;

	// Ownership changed only exists when the management interrupt pin does
	assign evt_impl = SMI_PRESENT ? EVT_IMPL_MASK : (EVT_IMPL_MASK & ~(32'h1 << EVT_OWN_CHANGED_BIT));

	// Slot 0 tracks the control list and slot 1 the bulk list; their filled bits sit side by side
	for (genvar li = 0; li < 2; li++) begin : g_list
		list_fill_tracker tracker (
			.clk(REF_CLK),
			.rst_n(RST_N),
			.sw_set(cmd_wr && REG_WDATA[CMD_CTRL_FILLED_BIT + li]),
			.clear(busy),
			.evt(list_evt_gated[li]),
			.filled(list_filled[li]),
			.result(list_result[li])
		);
	end

	assign ctrl_filled = list_filled[0];
	assign bulk_filled = list_filled[1];
	assign CTRL_LIST_RESULT = list_result[0];
	assign BULK_LIST_RESULT = list_result[1];

	event_edge_detect edges (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.frame_msb(FRAME_MSB),
		.resume_signal(RESUME_SIGNAL),
		.sw_resume(SW_RESUME),
		.frame_overflow(frame_overflow),
		.resume_onset(resume_onset)
	);

	// Readback view of the command register; unused positions stay zero
	always_comb begin
		cmd_read = REG_RESET_VALUE;
		cmd_read[CMD_SOFT_RESET_BIT] = state_reg.soft_reset;
		cmd_read[CMD_CTRL_FILLED_BIT] = ctrl_filled;
		cmd_read[CMD_BULK_FILLED_BIT] = bulk_filled;
		cmd_read[CMD_OWN_REQ_BIT] = state_reg.own_req;
		cmd_read[OVERRUN_COUNT_LSB +: OVERRUN_COUNT_W] = state_reg.overrun_cnt;
	end

	always_comb begin
		evt_set = REG_RESET_VALUE;
		evt_set[EVT_OVERRUN_BIT] = SCHED_OVERRUN;
		evt_set[EVT_DONE_HEAD_BIT] = DONE_HEAD_COPIED;
		evt_set[EVT_FRAME_START_BIT] = FRAME_START;
		evt_set[EVT_RESUME_BIT] = resume_onset;
		evt_set[EVT_FATAL_BIT] = FATAL_ERROR;
		evt_set[EVT_FRAME_OVF_BIT] = frame_overflow;
		evt_set[EVT_ROOTHUB_BIT] = ROOTHUB_CHANGE;
		evt_set[EVT_OWN_CHANGED_BIT] = state_reg.own_req;
	end

	always_comb begin
		state_next = state_reg;
		state_next.ack = 1'b0;

		// Write-one-to-clear, with a same-cycle hardware set winning
		if (evt_wr) begin
			state_next.evt = state_reg.evt & ~REG_WDATA;
		end
		state_next.evt = (state_next.evt | evt_set) & evt_impl;

		if (SCHED_OVERRUN) begin
			state_next.overrun_cnt = state_reg.overrun_cnt + 2'h1;
		end

		if (FATAL_ERROR) begin
			state_next.halted = 1'b1;
		end

		if (OWNERSHIP_DONE) begin
			state_next.own_req = 1'b0;
		end

		case (state_reg.rst_state)
			RST_IDLE: begin
				if (state_reg.soft_reset) begin
					state_next.rst_state = RST_BUSY;
					state_next.rst_cnt = '0;
				end
			end
			RST_BUSY: begin
				state_next.rst_cnt = state_reg.rst_cnt + 9'h001;
				if (state_reg.rst_cnt == SOFT_RESET_CYCLES - 9'h001) begin
					state_next.rst_state = RST_IDLE;
					state_next.soft_reset = 1'b0;
				end
			end
			default: begin
				state_next.rst_state = RST_IDLE;
			end
		endcase

		// Operational state is held at reset values while the soft reset runs
		if (busy) begin
			state_next.evt = REG_RESET_VALUE;
			state_next.overrun_cnt = '0;
			state_next.own_req = 1'b0;
			state_next.halted = 1'b0;
		end

		// Command bits written as one are set last, so they win over any clear
		if (cmd_wr) begin
			if (REG_WDATA[CMD_SOFT_RESET_BIT]) begin
				state_next.soft_reset = 1'b1;
			end
			if (REG_WDATA[CMD_OWN_REQ_BIT]) begin
				state_next.own_req = 1'b1;
			end
		end

		if (REG_CS) begin
			state_next.ack = 1'b1;
		end
		if (reg_rd) begin
			if (REG_ADDR == CMD_STATUS_OFFSET) begin
				state_next.rdata = cmd_read;
			end else if (REG_ADDR == EVENT_STATUS_OFFSET) begin
				state_next.rdata = state_reg.evt;
			end else begin
				state_next.rdata = REG_RESET_VALUE;
			end
		end

		// Interrupts follow the flags that will be visible next cycle
		state_next.irq = EVENT_ENABLE[MASTER_IRQ_BIT] && (|(state_next.evt[30:0] & EVENT_ENABLE[30:0]));
		state_next.smi_n = !(state_next.evt[EVT_OWN_CHANGED_BIT] && EVENT_ENABLE[EVT_OWN_CHANGED_BIT]);
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= CTL_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign REG_RDATA = state_reg.rdata;
	assign REG_ACK = state_reg.ack;
	assign HOST_IRQ = state_reg.irq;
	assign SYSTEM_MGMT_IRQ_N = state_reg.smi_n;
	// Next writeback may only go out once software has cleared the done-head flag
	assign DONE_HEAD_UPDATE_OK = !state_reg.evt[EVT_DONE_HEAD_BIT];
	assign SOFT_RESET_BUSY = busy;
	// No root hub or port reset output exists; the soft reset only reaches the schedule side
	assign FORCE_USB_SUSPEND = busy;
	assign BUS_ACCESS_INHIBIT = busy || state_reg.halted;
	assign PROCESSING_HALT = state_reg.halted;

endmodule

// File: verification/ohci_cmd_status_chk.sv
// Port-level assertions for the command and event status block.
// Assumes it is bound into the block and sees only its ports on REF_CLK.
`timescale 1ns/100ps
module ohci_cmd_status_chk
	import ohci_cmd_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic REG_CS,
	input wire logic REG_WE,
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_ACK,
	input wire logic [31:0] EVENT_ENABLE,
	input wire logic HOST_IRQ,
	input wire logic SCHED_OVERRUN,
	input wire logic SYSTEM_MGMT_IRQ_N,
	input wire logic SOFT_RESET_BUSY,
	input wire logic FORCE_USB_SUSPEND,
	input wire logic BUS_ACCESS_INHIBIT,
	input wire logic FATAL_ERROR,
	input wire logic PROCESSING_HALT,
	input wire list_evt_t CTRL_LIST_EVT,
	input wire list_result_t CTRL_LIST_RESULT
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	// A write during a running reset does not restart the count
	sequence sr_req;
		REG_CS && REG_WE && REG_ADDR == CMD_STATUS_OFFSET && REG_WDATA[0] && !SOFT_RESET_BUSY;
	endsequence
	sequence sr_run;
		##2 SOFT_RESET_BUSY ##[1:500] !SOFT_RESET_BUSY;
	endsequence
	ack_follows_cs_a: assert property (1'b1 |=> REG_ACK == $past(REG_CS))
		else $error("acknowledge does not follow request");
	master_gate_a: assert property (!EVENT_ENABLE[31] |=> !HOST_IRQ)
		else $error("interrupt raised with master enable off");
	overrun_irq_a: assert property (SCHED_OVERRUN && EVENT_ENABLE[31] && EVENT_ENABLE[0] && !SOFT_RESET_BUSY
		|=> HOST_IRQ) else $error("enabled overrun raised no interrupt");
	smi_enable_a: assert property ($fell(SYSTEM_MGMT_IRQ_N) |-> $past(EVENT_ENABLE[30]))
		else $error("management interrupt while masked");
	reset_length_a: assert property (sr_req |-> sr_run)
		else $error("soft reset missing or too long");
	reset_suspend_a: assert property (SOFT_RESET_BUSY |-> FORCE_USB_SUSPEND && BUS_ACCESS_INHIBIT)
		else $error("soft reset without suspend and bus block");
	fatal_halt_a: assert property (FATAL_ERROR && !SOFT_RESET_BUSY |=> PROCESSING_HALT && BUS_ACCESS_INHIBIT)
		else $error("fatal error did not halt");
	halt_release_a: assert property ($fell(PROCESSING_HALT) |-> SOFT_RESET_BUSY)
		else $error("halt left without soft reset");
	ctrl_head_a: assert property (CTRL_LIST_EVT.head_reached && !BUS_ACCESS_INHIBIT
		|=> CTRL_LIST_RESULT.start != CTRL_LIST_RESULT.skip) else $error("list head not answered");
endmodule
bind ohci_command_and_event_status ohci_cmd_status_chk i_ohci_cmd_status_chk (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_CS(REG_CS), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK), .EVENT_ENABLE(EVENT_ENABLE), .HOST_IRQ(HOST_IRQ),
	.SCHED_OVERRUN(SCHED_OVERRUN), .SYSTEM_MGMT_IRQ_N(SYSTEM_MGMT_IRQ_N), .SOFT_RESET_BUSY(SOFT_RESET_BUSY),
	.FORCE_USB_SUSPEND(FORCE_USB_SUSPEND), .BUS_ACCESS_INHIBIT(BUS_ACCESS_INHIBIT), .FATAL_ERROR(FATAL_ERROR),
	.PROCESSING_HALT(PROCESSING_HALT), .CTRL_LIST_EVT(CTRL_LIST_EVT), .CTRL_LIST_RESULT(CTRL_LIST_RESULT));

// File: verification/host_driver_model.sv
// Host driver software model issuing single-word register accesses.
// Assumes every access is answered by a one-cycle acknowledge.
`timescale 1ns/100ps
module host_driver_model
	import ohci_cmd_pkg::*;
(
	input wire logic clk,
	input wire logic ack,
	input wire logic [31:0] rdata,
	output logic cs,
	output logic we,
	output logic [ADDR_W-1:0] addr,
	output logic [31:0] wdata
);
	initial begin
		cs = 1'b0;
		we = 1'b0;
		addr = 8'ha5;
		wdata = 32'h5a5a_5a5a;
	end
	// Released lines show the inverse so a stale value never passes as valid
	task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic k);
		@(posedge clk);
		#1;
		cs = 1'b1;
		we = w;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		cs = 1'b0;
		we = ~w;
		addr = ~a;
		wdata = ~d;
		q = rdata;
		k = ack;
	endtask
	task automatic add_td(input int l);
		logic [31:0] q;
		logic k;
		access(1'b1, CMD_STATUS_OFFSET, 32'h2 << l, q, k);
	endtask
endmodule

// File: verification/test_ohci_command_and_event_status.sv
// Self-checking bench for the command and event status block.
// Assumes the host driver model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module test_ohci_command_and_event_status;
	import ohci_cmd_pkg::*;
	logic REF_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic cs, we, ack, host_irq, smi_n, ok, busy, sus, inh, halt, msb, resume, sw_res;
	logic [7:0] addr;
	logic [7:0] ev;
	logic [31:0] wdata, rdata, en;
	list_evt_t cev, bev;
	list_result_t cres, bres;
	logic [8:0] n;
	int bits[3] = '{1, 2, 6};
	int errors = 0;
	int cmp_count = 0;
	always #10 REF_CLK = ~REF_CLK;
	host_driver_model i_host_driver_model (.clk(REF_CLK), .ack(ack), .rdata(rdata), .cs(cs), .we(we),
		.addr(addr), .wdata(wdata));
	ohci_command_and_event_status #(.SMI_PRESENT(1'b1)) i_ohci_command_and_event_status (
		.REF_CLK(REF_CLK), .RST_N(RST_N), .REG_CS(cs), .REG_WE(we), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .REG_ACK(ack), .EVENT_ENABLE(en), .SCHED_OVERRUN(ev[0]), .DONE_HEAD_COPIED(ev[1]),
		.FRAME_START(ev[2]), .FRAME_MSB(msb), .RESUME_SIGNAL(resume), .SW_RESUME(sw_res), .FATAL_ERROR(ev[4]),
		.ROOTHUB_CHANGE(ev[6]), .OWNERSHIP_DONE(ev[7]), .CTRL_LIST_EVT(cev), .BULK_LIST_EVT(bev),
		.CTRL_LIST_RESULT(cres), .BULK_LIST_RESULT(bres), .DONE_HEAD_UPDATE_OK(ok), .SOFT_RESET_BUSY(busy),
		.FORCE_USB_SUSPEND(sus), .BUS_ACCESS_INHIBIT(inh), .PROCESSING_HALT(halt), .HOST_IRQ(host_irq),
		.SYSTEM_MGMT_IRQ_N(smi_n));
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		logic k;
		i_host_driver_model.access(1'b0, a, 32'h0, q, k);
		check({31'h0, k}, 32'h1);
		check(q & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic k;
		i_host_driver_model.access(1'b1, a, d, q, k);
	endtask
	task automatic pulse(input int b);
		@(posedge REF_CLK);
		#1;
		ev[b] = 1'b1;
		@(posedge REF_CLK);
		#1;
		ev[b] = 1'b0;
	endtask
	// Result pulses stand one cycle, so they are sampled right after the answering edge
	task automatic lev(input int l, input list_evt_t e, input list_result_t x);
		@(posedge REF_CLK);
		#1;
		cev = (l == 0) ? e : 3'h0;
		bev = (l == 0) ? 3'h0 : e;
		@(posedge REF_CLK);
		#1;
		cev = 3'h0;
		bev = 3'h0;
		check({29'h0, (l == 0) ? cres : bres}, {29'h0, x});
	endtask
	initial begin
		repeat (5000) @(posedge REF_CLK);
		errors++;
		close_out();
	end
	initial begin
		{ev, en, msb, resume, sw_res, cev, bev} = '0;
		repeat (3) @(posedge REF_CLK);
		#1;
		RST_N = 1'b1;
		check({31'h0, ok}, 32'h1);
		rd_chk(CMD_STATUS_OFFSET, '1, 32'h0);
		rd_chk(EVENT_STATUS_OFFSET, '1, 32'h0);
		wr(8'h10, 32'hffff_ffff);
		rd_chk(8'h10, '1, 32'h0);
		wr(CMD_STATUS_OFFSET, 32'h2);
		wr(CMD_STATUS_OFFSET, 32'hffff_fff4);
		rd_chk(CMD_STATUS_OFFSET, '1, 32'h6);
		for (int l = 0; l < 2; l++) begin
			i_host_driver_model.add_td(l);
			lev(l, 3'b100, 3'b100);
			rd_chk(CMD_STATUS_OFFSET, 32'h2 << l, 32'h0);
			lev(l, 3'b100, 3'b010);
			lev(l, 3'b010, 3'b000);
			rd_chk(CMD_STATUS_OFFSET, 32'h2 << l, 32'h2 << l);
			lev(l, 3'b001, 3'b000);
			lev(l, 3'b100, 3'b100);
			lev(l, 3'b001, 3'b001);
		end
		en = 32'h8000_0001;
		for (int i = 1; i <= 5; i++) begin
			pulse(0);
			rd_chk(CMD_STATUS_OFFSET, 32'h3_0000, 32'(i % 4) << 16);
		end
		rd_chk(EVENT_STATUS_OFFSET, '1, 32'h1);
		check({31'h0, host_irq}, 32'h1);
		wr(EVENT_STATUS_OFFSET, 32'h0);
		rd_chk(EVENT_STATUS_OFFSET, '1, 32'h1);
		wr(EVENT_STATUS_OFFSET, 32'h1);
		rd_chk(EVENT_STATUS_OFFSET, '1, 32'h0);
		check({31'h0, host_irq}, 32'h0);
		for (int j = 0; j < 3; j++) begin
			en = {j == 2, 31'h7fff_ffff};
			pulse(bits[j]);
			rd_chk(EVENT_STATUS_OFFSET, '1, 32'h1 << bits[j]);
			check({31'h0, host_irq}, {31'h0, j == 2});
			check({31'h0, ok}, {31'h0, bits[j] != 1});
			wr(EVENT_STATUS_OFFSET, 32'hffff_ffff);
		end
		msb = 1'b1;
		sw_res = 1'b1;
		resume = 1'b1;
		repeat (4) @(posedge REF_CLK);
		rd_chk(EVENT_STATUS_OFFSET, 32'h28, 32'h20);
		resume = 1'b0;
		sw_res = 1'b0;
		repeat (4) @(posedge REF_CLK);
		#1;
		resume = 1'b1;
		repeat (4) @(posedge REF_CLK);
		rd_chk(EVENT_STATUS_OFFSET, 32'h28, 32'h28);
		wr(EVENT_STATUS_OFFSET, 32'hffff_ffff);
		en = 32'h4000_0000;
		wr(CMD_STATUS_OFFSET, 32'h8);
		rd_chk(EVENT_STATUS_OFFSET, '1, 32'h4000_0000);
		check({31'h0, smi_n}, 32'h0);
		en = 32'h0;
		@(posedge REF_CLK);
		#1;
		check({31'h0, smi_n}, 32'h1);
		en = 32'h4000_0000;
		pulse(7);
		rd_chk(CMD_STATUS_OFFSET, 32'h8, 32'h0);
		wr(EVENT_STATUS_OFFSET, 32'h4000_0000);
		rd_chk(EVENT_STATUS_OFFSET, '1, 32'h0);
		check({31'h0, smi_n}, 32'h1);
		pulse(4);
		check({31'h0, halt}, 32'h1);
		check({30'h0, sus, inh}, 32'h1);
		lev(0, 3'b100, 3'b000);
		wr(CMD_STATUS_OFFSET, 32'h1);
		n = '0;
		for (int c = 0; c < 600 && (n == 0 || busy === 1'b1); c++) begin
			@(posedge REF_CLK);
			#1;
			if (busy === 1'b1) n++;
			if (busy === 1'b1 && n == 9'h001) begin
				check({30'h0, sus, inh}, 32'h3);
			end
		end
		check({23'h0, n}, {23'h0, SOFT_RESET_CYCLES});
		rd_chk(CMD_STATUS_OFFSET, '1, 32'h0);
		rd_chk(EVENT_STATUS_OFFSET, '1, 32'h0);
		check({31'h0, halt}, 32'h0);
		check({30'h0, sus, inh}, 32'h0);
		close_out();
	end
endmodule
